// ===== core/tx_stat_pkg.sv
package tx_stat_pkg;

    localparam int CNT_W = 32;
    localparam int ADDR_W = 16;
    localparam int LEN_W = 11;
    localparam int NUM_CNT = 10;

    // Register offsets (byte addresses)
    localparam logic [15:0] OFF_LEN64 = 16'h40D8;
    localparam logic [15:0] OFF_LEN127 = 16'h40DC;
    localparam logic [15:0] OFF_LEN255 = 16'h40E0;
    localparam logic [15:0] OFF_LEN511 = 16'h40E4;
    localparam logic [15:0] OFF_LEN1023 = 16'h40E8;
    localparam logic [15:0] OFF_LEN_MAX = 16'h40EC;
    localparam logic [15:0] OFF_MCAST = 16'h40F0;
    localparam logic [15:0] OFF_BCAST = 16'h40F4;
    localparam logic [15:0] OFF_SEG_DONE = 16'h40F8;
    localparam logic [15:0] OFF_SEG_FAIL = 16'h40FC;
    localparam logic [15:0] OFF_BASE = 16'h40D8;
    localparam logic [15:0] OFF_LAST = 16'h40FC;

    // Counter indices
    localparam int IDX_LEN64 = 0;
    localparam int IDX_LEN127 = 1;
    localparam int IDX_LEN255 = 2;
    localparam int IDX_LEN511 = 3;
    localparam int IDX_LEN1023 = 4;
    localparam int IDX_LEN_MAX = 5;
    localparam int IDX_MCAST = 6;
    localparam int IDX_BCAST = 7;
    localparam int IDX_SEG_DONE = 8;
    localparam int IDX_SEG_FAIL = 9;

    // Bin bounds, bytes from destination address through FCS
    localparam logic [10:0] LEN_64 = 11'h040;
    localparam logic [10:0] LEN_127 = 11'h07F;
    localparam logic [10:0] LEN_255 = 11'h0FF;
    localparam logic [10:0] LEN_511 = 11'h1FF;
    localparam logic [10:0] LEN_1023 = 11'h3FF;
    localparam logic [10:0] LEN_MAX = 11'h5F2;

    localparam logic [31:0] CNT_RESET = 32'h0000_0000;
    localparam logic [31:0] CNT_ONE = 32'h0000_0001;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    // One completed transmit frame report
    typedef struct packed {
        logic             valid;
        logic [10:0]      length;
        logic             collided;
        logic             half_duplex;
        logic             flow_ctrl;
        logic             multicast;
        logic             broadcast;
    } tx_frame_t;

    // Segmentation offload context events
    typedef struct packed {
        logic seg_last;
        logic seg_excess_coll;
        logic seg_len_err;
        logic seg_ctx_end;
    } seg_event_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

endpackage : tx_stat_pkg

// ===== core/tx_statistics_counters.sv
// Chosen here: strobed register access.
`timescale 1ns/1ps
// Overview of operation
// - Count frames of exactly 64 bytes in the smallest bin.
// - Frame length spans destination address through FCS inclusive.
// - Half-duplex collision-truncated frames go in no length bin.
// - Flow control frames never enter the 64-byte bin.
// - No counter moves while the transmitter is disabled.
// - Length bins count host, secured, sideband and alerting frames alike.
// - Count 65 to 127 byte frames in the second bin.
// - Count 128 to 255 byte frames in the third bin.
// - Count 256 to 511 byte frames in the fourth bin.
// - Count 512 to 1023 byte frames in the fifth bin.
// - Count 1024 bytes and up, 1522 included, in the largest bin.
// - No transmitted frame exceeds 1522 bytes; longer reports still count in the largest bin and set len_violation.
// - Count multicast frames once each, flow control excluded.
// - Count broadcast-addressed frames once each.
// - Multicast and broadcast counts include secured and clear frames.
// - Count a context when its last segment lands in the buffer.
// - Context count needs both transmit and offload enabled.
// - At most one failure counted per offload context.
// - Excess collisions or payload length error mark context failed.
// - Only the failure count is kept, no partial payload figure.
// - Each counter is 32 bits wide and zero after reset.
module tx_statistics_counters #(
    parameter int CNT_W = tx_stat_pkg::CNT_W
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst_b,
    input  wire tx_stat_pkg::reg_req_t  reg_req,
    output logic [31:0]                 reg_rdata,
    input  wire tx_stat_pkg::tx_frame_t tx_frame,
    input  wire tx_stat_pkg::seg_event_t seg_event,
    input  wire logic                   tx_enable,
    input  wire logic                   seg_offload_enable,
    output logic                        len_violation
);

    typedef enum logic [0:0] {
        CTX_OK,
        CTX_FAILED
    } ctx_state_t;

    logic [CNT_W-1:0] cnt_ff [tx_stat_pkg::NUM_CNT];
    logic [tx_stat_pkg::NUM_CNT-1:0] inc;
    ctx_state_t ctx_ff;
    ctx_state_t nxt_ctx;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        viol_ff;

    // Length is the full frame, DA through FCS, as supplied by the MAC
    wire logic [10:0] len = tx_frame.length;
    // Source of the frame is irrelevant: every path reports here
    wire logic frame_ok = tx_frame.valid && tx_enable;
    wire logic bin_ok = frame_ok
        && !(tx_frame.collided && tx_frame.half_duplex);

    assign inc[tx_stat_pkg::IDX_LEN64] = bin_ok && !tx_frame.flow_ctrl
        && (len == tx_stat_pkg::LEN_64);
    assign inc[tx_stat_pkg::IDX_LEN127] = bin_ok
        && (len > tx_stat_pkg::LEN_64)
        && (len <= tx_stat_pkg::LEN_127);
    assign inc[tx_stat_pkg::IDX_LEN255] = bin_ok
        && (len > tx_stat_pkg::LEN_127)
        && (len <= tx_stat_pkg::LEN_255);
    assign inc[tx_stat_pkg::IDX_LEN511] = bin_ok
        && (len > tx_stat_pkg::LEN_255)
        && (len <= tx_stat_pkg::LEN_511);
    assign inc[tx_stat_pkg::IDX_LEN1023] = bin_ok
        && (len > tx_stat_pkg::LEN_511)
        && (len <= tx_stat_pkg::LEN_1023);
    // Upper bin is open-ended so 1522-byte tagged frames land here
    assign inc[tx_stat_pkg::IDX_LEN_MAX] = bin_ok
        && (len > tx_stat_pkg::LEN_1023);
    assign inc[tx_stat_pkg::IDX_MCAST] = frame_ok
        && tx_frame.multicast && !tx_frame.flow_ctrl;
    assign inc[tx_stat_pkg::IDX_BCAST] = frame_ok
        && tx_frame.broadcast;
    assign inc[tx_stat_pkg::IDX_SEG_DONE] = seg_event.seg_last
        && tx_enable && seg_offload_enable;

    // Failure during a context: counted on first hit, then latched
    wire logic fail_hit = seg_event.seg_excess_coll
        || seg_event.seg_len_err;
    assign inc[tx_stat_pkg::IDX_SEG_FAIL] = fail_hit && tx_enable
        && (ctx_ff == CTX_OK);

    always_comb
    begin
        nxt_ctx = ctx_ff;
        case (ctx_ff)
            CTX_OK:
            begin
                if (fail_hit && tx_enable && !seg_event.seg_ctx_end)
                    nxt_ctx = CTX_FAILED;
            end
            CTX_FAILED:
            begin
                // Context boundary rearms the failure latch
                if (seg_event.seg_ctx_end)
                    nxt_ctx = CTX_OK;
            end
            default:
                nxt_ctx = CTX_OK;
        endcase
    end

    // Counters wrap at 32 bits; none saturates
    generate
        for (genvar i = 0; i < tx_stat_pkg::NUM_CNT; i++)
        begin : g_cnt
            always_ff @(posedge sys_clk or negedge rst_b)
            begin
                if (!rst_b)
                    cnt_ff[i] <= CNT_W'(tx_stat_pkg::CNT_RESET);
                else if (inc[i])
                    cnt_ff[i] <= cnt_ff[i] + CNT_W'(tx_stat_pkg::CNT_ONE);
            end
        end
    endgenerate

    // Read decode; writes are not decoded at all
    wire logic in_range = (reg_req.addr >= tx_stat_pkg::OFF_BASE)
        && (reg_req.addr <= tx_stat_pkg::OFF_LAST)
        && (reg_req.addr[1:0] == 2'h0);
    wire logic [15:0] rel = reg_req.addr - tx_stat_pkg::OFF_BASE;
    wire logic [3:0] rd_idx = rel[5:2];

    always_comb
    begin
        nxt_rdata = tx_stat_pkg::RD_UNMAPPED;
        if (reg_req.rd && in_range)
            nxt_rdata = 32'(cnt_ff[rd_idx]);
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_ff <= tx_stat_pkg::RD_UNMAPPED;
            ctx_ff   <= CTX_OK;
            viol_ff  <= 1'b0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            ctx_ff   <= nxt_ctx;
            // Flags a MAC that reports a frame beyond the tagged maximum
            viol_ff  <= tx_frame.valid && (len > tx_stat_pkg::LEN_MAX);
        end
    end

    assign reg_rdata = rdata_ff;
    assign len_violation = viol_ff;

endmodule : tx_statistics_counters

// ===== verif/tx_stat_sva.sv
`timescale 1ns/1ps
module tx_stat_sva #(
    parameter int CNT_W = 32
) (
    input wire logic                    sys_clk,
    input wire logic                    rst_b,
    input wire tx_stat_pkg::reg_req_t   reg_req,
    input wire logic [31:0]             reg_rdata,
    input wire tx_stat_pkg::tx_frame_t  tx_frame,
    input wire tx_stat_pkg::seg_event_t seg_event,
    input wire logic                    tx_enable,
    input wire logic                    seg_offload_enable,
    input wire logic                    len_violation
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire fv = tx_frame.valid && tx_enable;
    wire fc = tx_frame.flow_ctrl;
    // Event beside the first of two reads of one address
    sequence s_reread(a, ev);
        reg_req.rd && reg_req.addr == a && ev
        ##1 reg_req.rd && reg_req.addr == a;
    endsequence
    property p_step(a, ev, d);
        s_reread(a, ev) |=> reg_rdata == $past(reg_rdata) + d;
    endproperty
    chk_len64_bump: assert property (p_step(tx_stat_pkg::OFF_LEN64, fv && !fc
        && !(tx_frame.collided && tx_frame.half_duplex)
        && tx_frame.length == tx_stat_pkg::LEN_64, 32'h1)) else $error("64 bin");
    chk_fc_skip: assert property (p_step(tx_stat_pkg::OFF_LEN64,
        fv && fc, 32'h0)) else $error("flow frame in 64 bin");
    chk_coll_skip: assert property (p_step(tx_stat_pkg::OFF_LEN64, fv
        && tx_frame.collided && tx_frame.half_duplex, 32'h0)) else $error("coll");
    chk_tx_off_hold: assert property (p_step(tx_stat_pkg::OFF_LEN64,
        !tx_enable, 32'h0)) else $error("count moved while disabled");
    chk_seg_gate: assert property (p_step(tx_stat_pkg::OFF_SEG_DONE,
        !seg_offload_enable, 32'h0)) else $error("context count ungated");
    chk_mcast_bump: assert property (p_step(tx_stat_pkg::OFF_MCAST,
        fv && tx_frame.multicast && !fc, 32'h1)) else $error("multicast");
    chk_unmapped_zero: assert property (reg_req.rd
        && (reg_req.addr < tx_stat_pkg::OFF_BASE || reg_req.addr[1:0] != 2'h0
        || reg_req.addr > tx_stat_pkg::OFF_LAST) |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_oversize_flag: assert property (tx_frame.valid
        && tx_frame.length > tx_stat_pkg::LEN_MAX |=> len_violation)
        else $error("oversize frame not flagged");
    chk_flag_cause: assert property (len_violation |-> $past(tx_frame.valid
        && tx_frame.length > tx_stat_pkg::LEN_MAX)) else $error("false flag");
endmodule : tx_stat_sva
bind tx_statistics_counters tx_stat_sva #(.CNT_W(CNT_W)) i_tx_stat_sva (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .tx_frame(tx_frame), .seg_event(seg_event),
    .tx_enable(tx_enable), .seg_offload_enable(seg_offload_enable),
    .len_violation(len_violation));

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic                    sys_clk = 1'b0;
    logic                    rst_b = 1'b0;
    tx_stat_pkg::reg_req_t   req = '0;
    logic [31:0]             rdata;
    tx_stat_pkg::tx_frame_t  frm = '0;
    tx_stat_pkg::seg_event_t seg = '0;
    logic                    tx_en = 1'b1;
    logic                    seg_en = 1'b1;
    logic                    latch = 1'b0;
    logic                    viol;
    logic [31:0]             cnt [10] = '{default: 32'h0};
    int                      err_count = 0;
    int                      check_count = 0;
    int ln [11] = '{64, 65, 127, 128, 255, 256, 511, 512, 1023, 1024, 1522};
    always #20 sys_clk = ~sys_clk;
    tx_statistics_counters i_tx_statistics_counters (
        .sys_clk(sys_clk), .rst_b(rst_b), .reg_req(req), .reg_rdata(rdata),
        .tx_frame(frm), .seg_event(seg), .tx_enable(tx_en),
        .seg_offload_enable(seg_en), .len_violation(viol));
    function automatic int bin(int l);
        return l <= 64 ? 0 : l <= 127 ? 1 : l <= 255 ? 2 : l <= 511 ? 3
            : l <= 1023 ? 4 : 5;
    endfunction : bin
    function automatic tx_stat_pkg::tx_frame_t mk(int l, logic [4:0] fl);
        return tx_stat_pkg::tx_frame_t'({1'b1, l[10:0], fl});
    endfunction : mk
    task automatic chk(logic [15:0] a);
        logic [31:0] e;
        e = (a >= tx_stat_pkg::OFF_BASE && a <= tx_stat_pkg::OFF_LAST
            && a[1:0] == 2'h0) ? cnt[(a - tx_stat_pkg::OFF_BASE) >> 2] : 32'h0;
        check_count++;
        if (rdata !== e)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, rdata, e);
        end
    endtask : chk
    // Expected counts; failure latch only matters while enabled
    task automatic model(tx_stat_pkg::tx_frame_t f, tx_stat_pkg::seg_event_t s);
        if (tx_en && f.valid && !(f.collided && f.half_duplex)
            && !(f.flow_ctrl && f.length == 11'h040)) cnt[bin(f.length)]++;
        if (tx_en && f.valid && f.multicast && !f.flow_ctrl) cnt[6]++;
        if (tx_en && f.valid && f.broadcast) cnt[7]++;
        if (tx_en && s.seg_last && seg_en) cnt[8]++;
        if (tx_en && (s.seg_excess_coll || s.seg_len_err) && !latch) cnt[9]++;
        if (tx_en) latch = (latch || s.seg_excess_coll || s.seg_len_err)
            && !s.seg_ctx_end;
    endtask : model
    // Event beside first read, second read sees its effect
    task automatic step(tx_stat_pkg::tx_frame_t f, tx_stat_pkg::seg_event_t s,
                        logic [15:0] a);
        @(posedge sys_clk);
        req.rd <= 1'b1;
        req.addr <= a;
        frm <= f;
        seg <= s;
        @(posedge sys_clk);
        frm <= '0;
        seg <= '0;
        @(negedge sys_clk);
        chk(a);
        // Flag stands only in the cycle after the frame report
        check_count++;
        if (viol !== (f.valid && f.length > tx_stat_pkg::LEN_MAX))
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, viol,
                     f.valid && f.length > tx_stat_pkg::LEN_MAX);
        end
        model(f, s);
        @(posedge sys_clk);
        req.rd <= 1'b0;
        @(negedge sys_clk);
        chk(a);
    endtask : step
    task automatic wr(logic [15:0] a);
        @(posedge sys_clk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= 32'hFFFF_FFFF;
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask : wr
    task close_out;
        if (err_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 12; i++)
            step('0, '0, tx_stat_pkg::OFF_BASE + 16'(4 * i));
        step('0, '0, 16'h40DA);
        wr(tx_stat_pkg::OFF_LEN64);
        step(mk(64, 5'h00), '0, tx_stat_pkg::OFF_LEN64);
        for (int k = 0; k < 11; k++)
            step(mk(ln[k], 5'h00), '0, 16'h40D8 + 16'(4 * bin(ln[k])));
        step(mk(64, 5'h04), '0, tx_stat_pkg::OFF_LEN64);
        step(mk(64, 5'h18), '0, tx_stat_pkg::OFF_LEN64);
        step(mk(200, 5'h02), '0, tx_stat_pkg::OFF_MCAST);
        step(mk(64, 5'h06), '0, tx_stat_pkg::OFF_MCAST);
        step(mk(1522, 5'h01), '0, tx_stat_pkg::OFF_BCAST);
        step('0, 4'h8, tx_stat_pkg::OFF_SEG_DONE);
        for (int j = 0; j < 4; j++)
            step('0, 4'(4 >> j), tx_stat_pkg::OFF_SEG_FAIL);
        step('0, 4'h2, tx_stat_pkg::OFF_SEG_FAIL);
        seg_en <= 1'b0;
        step('0, 4'h8, tx_stat_pkg::OFF_SEG_DONE);
        tx_en <= 1'b0;
        step(mk(64, 5'h00), 4'h4, tx_stat_pkg::OFF_LEN64);
        step(mk(1523, 5'h00), '0, tx_stat_pkg::OFF_LEN_MAX);
        close_out();
    end
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        err_count++;
        close_out();
    end
endmodule : tb_top
